// File: hdl/card_host_pkg.sv
package card_host_pkg;

    localparam int CLK_NS = 4;

    // Pin timing of the card, in nanoseconds
    localparam int RESET_PULSE_NS = 100;
    localparam int SETUP_NS = 30;
    localparam int ACCESS_NS = 200;
    localparam int STROBE_NS = 100;
    localparam int HOLD_NS = 30;
    localparam int WAKE_TO_READ_DELAY_NS = 1000;
    localparam int RESET_TO_WRITE_DELAY_NS = 1000;

    // Least times round up to whole cycles
    localparam int RESET_PULSE_CYC = (RESET_PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int SYNC_LAG_CYC = 2;
    localparam int ACCESS_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS + SYNC_LAG_CYC;
    localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
    localparam int HOLD_CYC = (HOLD_NS + CLK_NS - 1) / CLK_NS;
    localparam int WAKE_TO_READ_CYC = (WAKE_TO_READ_DELAY_NS + CLK_NS - 1) / CLK_NS;
    localparam int RESET_TO_WRITE_CYC = (RESET_TO_WRITE_DELAY_NS + CLK_NS - 1) / CLK_NS;
    localparam int WAKE_CYC = (WAKE_TO_READ_CYC > RESET_TO_WRITE_CYC) ?
        WAKE_TO_READ_CYC : RESET_TO_WRITE_CYC;

    localparam int TIMER_W = 12;
    localparam int ADDR_W = 26;
    localparam int DATA_W = 16;

    // Register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] ADDR_OFS = 8'h04;
    localparam logic [7:0] WDATA_OFS = 8'h08;
    localparam logic [7:0] RDATA_OFS = 8'h0c;
    localparam logic [7:0] STATUS_OFS = 8'h10;

    // Control fields
    localparam int CTRL_GO_BIT = 0;
    localparam int CTRL_WRITE_BIT = 1;
    localparam int CTRL_LANE_LSB = 2;
    localparam int CTRL_CMD_BIT = 4;
    localparam int CTRL_PDOWN_BIT = 5;
    localparam int CTRL_RESET_BIT = 6;
    localparam int CTRL_WAIT_RDY_BIT = 7;

    // Status fields
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_READY_BIT = 1;
    localparam int ST_WP_BIT = 2;
    localparam int ST_DONE_BIT = 3;
    localparam int ST_REFUSED_BIT = 4;
    localparam int ST_OFFLINE_BIT = 5;

    localparam logic [1:0] LANE_EVEN = 2'h1;
    localparam logic [1:0] LANE_ODD = 2'h2;
    localparam logic [1:0] LANE_WORD = 2'h3;

    localparam logic [7:0] CTRL_RESET_VAL = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_RESET_VAL = 26'h0;
    localparam logic [DATA_W-1:0] DATA_RESET_VAL = 16'h0;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic even_lane_enable_n;
        logic odd_lane_enable_n;
        logic oe_n;
        logic we_n;
        logic reset;
        logic [DATA_W-1:0] dout;
        logic dout_oe;
    } card_pins_t;

    localparam card_pins_t PINS_IN_RESET = '{
        addr: 26'h0, even_lane_enable_n: 1'b1, odd_lane_enable_n: 1'b1,
        oe_n: 1'b1, we_n: 1'b1, reset: 1'b1, dout: 16'h0, dout_oe: 1'b0};

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } wb_req_t;

    typedef enum logic [2:0] {
        S_RESET,
        S_WAKE,
        S_IDLE,
        S_WAIT_RDY,
        S_SETUP,
        S_STROBE,
        S_HOLD
    } host_state_t;

endpackage

// File: hdl/bit_sync.sv
`timescale 1ns/1ns
module bit_sync #(
    parameter int W = 1
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);
    logic [W-1:0] meta_q;

    initial begin
        if (W < 1) begin
            $error("bit_sync width must be positive");
        end
    end

    // First stage feeds only the second
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_q <= '0;
            sync_o <= '0;
        end else begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end
endmodule

// File: hdl/card_timer.sv
`timescale 1ns/1ns
module card_timer #(
    parameter int W = 12
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic load_i,
    input wire logic [W-1:0] count_i,
    output logic expired_o
);
    logic [W-1:0] cnt_q;

    initial begin
        if (W < 2) begin
            $error("card_timer width too small");
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q <= '0;
        end else if (load_i) begin
            cnt_q <= count_i;
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
        end
    end

    // Pulse as the last counted cycle ends
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            expired_o <= 1'b0;
        end else begin
            expired_o <= (cnt_q == {{(W-1){1'b0}}, 1'b1}) && !load_i;
        end
    end
endmodule

// File: hdl/card_host.sv
// Summary of operation
// - Word read: both enables, output enable low
// - Hold card reset high at least 100 ns
// - Wait wake and recovery after reset
// - Reset card whenever host resets
// - Write strobe low under enable, rising latches
// - Same address for setup and confirm cycles
// - Command byte repeated on both lanes
//
// Added by the designer: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ns
module card_host #(
    parameter int WAKE_CYC = card_host_pkg::WAKE_CYC,
    parameter int ADDR_W = card_host_pkg::ADDR_W
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire card_host_pkg::wb_req_t wb_i,
    output logic wb_ack_o,
    output logic [31:0] wb_dat_o,
    output card_host_pkg::card_pins_t card_o,
    input wire logic [card_host_pkg::DATA_W-1:0] data_i,
    input wire logic ready_busy_n_i,
    input wire logic write_protect_i
);
    localparam int TW = card_host_pkg::TIMER_W;

    initial begin
        if (WAKE_CYC < 1 || WAKE_CYC >= (1 << TW)) begin
            $error("card_host WAKE_CYC out of timer range");
        end
        if (ADDR_W != card_host_pkg::ADDR_W) begin
            $error("card_host address width must match the card pins");
        end
    end

    card_host_pkg::host_state_t state_q;
    logic [7:0] ctrl_q;
    logic [ADDR_W-1:0] addr_q;
    logic [15:0] wdata_q;
    logic [15:0] rdata_q;
    logic op_write_q;
    logic op_cmd_q;
    logic [1:0] op_lane_q;
    logic done_q;
    logic refused_q;
    logic load_q;
    logic [TW-1:0] count_q;
    logic expired;
    logic [15:0] data_sync;
    logic ready_sync;
    logic wp_sync;
    logic wb_hit;
    logic wb_wr;
    logic ctrl_wr;
    logic go_req;
    logic reset_req;
    logic pdown;
    logic tick;

    bit_sync #(.W(16)) data_sync_u (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i(data_i),
        .sync_o(data_sync)
    );

    bit_sync #(.W(2)) pin_sync_u (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i({ready_busy_n_i, write_protect_i}),
        .sync_o({ready_sync, wp_sync})
    );

    card_timer #(.W(TW)) timer_u (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .load_i(load_q),
        .count_i(count_q),
        .expired_o(expired)
    );

    // Classic Wishbone decode, one request per ack
    assign wb_hit = wb_i.cyc && wb_i.stb && !wb_ack_o;
    assign wb_wr = wb_hit && wb_i.we && wb_i.sel[0];
    assign ctrl_wr = wb_wr && (wb_i.adr == card_host_pkg::CTRL_OFS);
    assign go_req = ctrl_wr && wb_i.dat[card_host_pkg::CTRL_GO_BIT];
    assign reset_req = ctrl_wr && wb_i.dat[card_host_pkg::CTRL_RESET_BIT];
    assign pdown = ctrl_q[card_host_pkg::CTRL_PDOWN_BIT];
    // Stale expiry right after a reload is ignored
    assign tick = expired && !load_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_hit;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= '0;
        end else if (wb_hit && !wb_i.we) begin
            unique case (wb_i.adr)
                card_host_pkg::CTRL_OFS: wb_dat_o <= {24'h0, ctrl_q};
                card_host_pkg::ADDR_OFS: wb_dat_o <= {{(32-ADDR_W){1'b0}}, addr_q};
                card_host_pkg::WDATA_OFS: wb_dat_o <= {16'h0, wdata_q};
                card_host_pkg::RDATA_OFS: wb_dat_o <= {16'h0, rdata_q};
                card_host_pkg::STATUS_OFS: begin
                    wb_dat_o <= '0;
                    wb_dat_o[card_host_pkg::ST_BUSY_BIT] <= (state_q != card_host_pkg::S_IDLE);
                    wb_dat_o[card_host_pkg::ST_READY_BIT] <= ready_sync;
                    wb_dat_o[card_host_pkg::ST_WP_BIT] <= wp_sync;
                    wb_dat_o[card_host_pkg::ST_DONE_BIT] <= done_q;
                    wb_dat_o[card_host_pkg::ST_REFUSED_BIT] <= refused_q;
                    wb_dat_o[card_host_pkg::ST_OFFLINE_BIT] <=
                        (state_q == card_host_pkg::S_RESET) || (state_q == card_host_pkg::S_WAKE);
                end
                default: wb_dat_o <= '0;
            endcase
        end
    end

    // Go and reset are self-clearing strobes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= card_host_pkg::CTRL_RESET_VAL;
        end else if (ctrl_wr) begin
            ctrl_q <= wb_i.dat[7:0];
            ctrl_q[card_host_pkg::CTRL_GO_BIT] <= 1'b0;
            ctrl_q[card_host_pkg::CTRL_RESET_BIT] <= 1'b0;
        end
    end

    // Address stays put between setup and confirm
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            addr_q <= card_host_pkg::ADDR_RESET_VAL;
        end else if (wb_wr && wb_i.adr == card_host_pkg::ADDR_OFS) begin
            addr_q <= wb_i.dat[ADDR_W-1:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wdata_q <= card_host_pkg::DATA_RESET_VAL;
        end else if (wb_wr && wb_i.adr == card_host_pkg::WDATA_OFS) begin
            wdata_q <= wb_i.dat[15:0];
        end
    end

    // Sticky flags: a new set beats the clear of a new go
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            done_q <= 1'b0;
            refused_q <= 1'b0;
        end else begin
            if (go_req) begin
                done_q <= 1'b0;
                refused_q <= 1'b0;
            end
            if (state_q == card_host_pkg::S_HOLD && tick) begin
                done_q <= 1'b1;
            end
            if (go_req && state_q == card_host_pkg::S_IDLE &&
                ((wb_i.dat[card_host_pkg::CTRL_WRITE_BIT] && wp_sync) ||
                 wb_i.dat[card_host_pkg::CTRL_LANE_LSB +: 2] == 2'h0)) begin
                refused_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_q <= card_host_pkg::DATA_RESET_VAL;
        end else if (state_q == card_host_pkg::S_STROBE && tick && !op_write_q) begin
            // Unselected lane floats, so it reads as zero
            rdata_q[7:0] <= op_lane_q[0] ? data_sync[7:0] : 8'h0;
            rdata_q[15:8] <= op_lane_q[1] ? data_sync[15:8] : 8'h0;
        end
    end

    // Sequencer for card reset, wake-up and bus cycles
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= card_host_pkg::S_RESET;
            card_o <= card_host_pkg::PINS_IN_RESET;
            load_q <= 1'b1;
            count_q <= TW'(card_host_pkg::RESET_PULSE_CYC);
            op_write_q <= 1'b0;
            op_cmd_q <= 1'b0;
            op_lane_q <= 2'h0;
        end else begin
            load_q <= 1'b0;
            if (reset_req) begin
                // Aborts any access in flight
                state_q <= card_host_pkg::S_RESET;
                card_o <= card_host_pkg::PINS_IN_RESET;
                load_q <= 1'b1;
                count_q <= TW'(card_host_pkg::RESET_PULSE_CYC);
            end else begin
                unique case (state_q)
                    card_host_pkg::S_RESET: begin
                        // Power-down bit keeps the card asleep
                        if (pdown) begin
                            load_q <= 1'b1;
                            count_q <= TW'(card_host_pkg::RESET_PULSE_CYC);
                        end else if (tick) begin
                            card_o.reset <= 1'b0;
                            state_q <= card_host_pkg::S_WAKE;
                            load_q <= 1'b1;
                            count_q <= TW'(WAKE_CYC);
                        end
                    end
                    card_host_pkg::S_WAKE: begin
                        if (pdown) begin
                            card_o.reset <= 1'b1;
                            state_q <= card_host_pkg::S_RESET;
                            load_q <= 1'b1;
                            count_q <= TW'(card_host_pkg::RESET_PULSE_CYC);
                        end else if (tick) begin
                            state_q <= card_host_pkg::S_IDLE;
                        end
                    end
                    card_host_pkg::S_IDLE: begin
                        if (pdown) begin
                            card_o.reset <= 1'b1;
                            state_q <= card_host_pkg::S_RESET;
                            load_q <= 1'b1;
                            count_q <= TW'(card_host_pkg::RESET_PULSE_CYC);
                        end else if (go_req &&
                            !(wb_i.dat[card_host_pkg::CTRL_WRITE_BIT] && wp_sync) &&
                            wb_i.dat[card_host_pkg::CTRL_LANE_LSB +: 2] != 2'h0) begin
                            op_write_q <= wb_i.dat[card_host_pkg::CTRL_WRITE_BIT];
                            op_cmd_q <= wb_i.dat[card_host_pkg::CTRL_CMD_BIT];
                            op_lane_q <= wb_i.dat[card_host_pkg::CTRL_LANE_LSB +: 2];
                            // Bit 0 never decoded by the card; bit 1 picks id code
                            card_o.addr <= {addr_q[ADDR_W-1:1], 1'b0};
                            if (wb_i.dat[card_host_pkg::CTRL_WRITE_BIT] &&
                                wb_i.dat[card_host_pkg::CTRL_WAIT_RDY_BIT]) begin
                                state_q <= card_host_pkg::S_WAIT_RDY;
                            end else begin
                                state_q <= card_host_pkg::S_SETUP;
                                load_q <= 1'b1;
                                count_q <= TW'(card_host_pkg::SETUP_CYC);
                            end
                        end
                    end
                    card_host_pkg::S_WAIT_RDY: begin
                        // Card busy with an algorithm; hold off next write
                        if (ready_sync) begin
                            state_q <= card_host_pkg::S_SETUP;
                            load_q <= 1'b1;
                            count_q <= TW'(card_host_pkg::SETUP_CYC);
                        end
                    end
                    card_host_pkg::S_SETUP: begin
                        if (!load_q && !op_write_q) begin
                            // Read: enable lanes and output enable together
                            card_o.even_lane_enable_n <= !op_lane_q[0];
                            card_o.odd_lane_enable_n <= !op_lane_q[1];
                            card_o.oe_n <= 1'b0;
                            card_o.we_n <= 1'b1;
                            card_o.dout_oe <= 1'b0;
                            state_q <= card_host_pkg::S_STROBE;
                            load_q <= 1'b1;
                            count_q <= TW'(card_host_pkg::ACCESS_CYC);
                        end else if (op_write_q) begin
                            card_o.even_lane_enable_n <= !op_lane_q[0];
                            card_o.odd_lane_enable_n <= !op_lane_q[1];
                            card_o.oe_n <= 1'b1;
                            card_o.dout_oe <= 1'b1;
                            card_o.dout <= op_cmd_q ? {wdata_q[7:0], wdata_q[7:0]}
                                                    : wdata_q;
                            if (tick) begin
                                card_o.we_n <= 1'b0;
                                state_q <= card_host_pkg::S_STROBE;
                                load_q <= 1'b1;
                                count_q <= TW'(card_host_pkg::STROBE_CYC);
                            end
                        end
                    end
                    card_host_pkg::S_STROBE: begin
                        if (tick) begin
                            // Rising write strobe latches; enables and data held on
                            card_o.we_n <= 1'b1;
                            card_o.oe_n <= 1'b1;
                            if (!op_write_q) begin
                                card_o.even_lane_enable_n <= 1'b1;
                                card_o.odd_lane_enable_n <= 1'b1;
                            end
                            state_q <= card_host_pkg::S_HOLD;
                            load_q <= 1'b1;
                            count_q <= TW'(card_host_pkg::HOLD_CYC);
                        end
                    end
                    card_host_pkg::S_HOLD: begin
                        if (tick) begin
                            card_o.even_lane_enable_n <= 1'b1;
                            card_o.odd_lane_enable_n <= 1'b1;
                            card_o.dout_oe <= 1'b0;
                            state_q <= card_host_pkg::S_IDLE;
                        end
                    end
                    default: state_q <= card_host_pkg::S_RESET;
                endcase
            end
        end
    end
endmodule

// File: sim/card_host_sva.sv
`timescale 1ns/1ns
module card_host_sva #(
    parameter int WAKE_CYC = 4,
    parameter int ADDR_W = 26
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire card_host_pkg::wb_req_t wb_i,
    input wire logic wb_ack_o,
    input wire logic [31:0] wb_dat_o,
    input wire card_host_pkg::card_pins_t card_o,
    input wire logic [card_host_pkg::DATA_W-1:0] data_i,
    input wire logic ready_busy_n_i,
    input wire logic write_protect_i
);
    logic [7:0] pulse_q;
    logic [11:0] quiet_q;
    logic [7:0] prot_q;
    logic sel;
    assign sel = !card_o.even_lane_enable_n || !card_o.odd_lane_enable_n;
    // Saturating counters keep long minimum times out of the properties
    always_ff @(posedge clk_i) begin
        pulse_q <= rst_i ? 8'h0 : !card_o.reset ? 8'h0 : pulse_q + 8'(pulse_q != 8'hff);
    end
    always_ff @(posedge clk_i) begin
        quiet_q <= (rst_i || card_o.reset) ? 12'h0 : quiet_q + 12'(quiet_q != 12'hfff);
    end
    always_ff @(posedge clk_i) begin
        prot_q <= (rst_i || !write_protect_i) ? 8'h0 : prot_q + 8'(prot_q != 8'hff);
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence req_s;
        wb_i.cyc && wb_i.stb && !wb_ack_o;
    endsequence
    sequence ack_s;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    bus_answer_a: assert property (req_s |=> ack_s)
        else $error("bus request not answered in one cycle");
    host_reset_a: assert property (disable iff (1'b0) rst_i |=> card_o.reset)
        else $error("card reset missing during host reset");
    read_drive_a: assert property (!card_o.oe_n |-> card_o.we_n && !card_o.dout_oe && sel)
        else $error("read strobe with bad lane state");
    strobe_gate_a: assert property (!card_o.we_n |-> sel && card_o.dout_oe && card_o.oe_n)
        else $error("write strobe without enable and data");
    reset_quiet_a: assert property (card_o.reset[*3] |-> !sel && card_o.we_n && card_o.oe_n)
        else $error("card strobed while in power-down");
    pulse_len_a: assert property ($fell(card_o.reset) |-> pulse_q >= 8'd25)
        else $error("card reset pulse too short");
    wake_wait_a: assert property ($rose(sel) |-> quiet_q >= 12'(WAKE_CYC))
        else $error("card accessed before wake time");
    addr_hold_a: assert property (sel && $past(sel) |-> $stable(card_o.addr))
        else $error("address moved inside an access");
    addr_even_a: assert property (!card_o.addr[0])
        else $error("address bit zero driven");
    protect_hold_a: assert property ($fell(card_o.we_n) |-> prot_q < 8'd40)
        else $error("write strobe while protected");
endmodule
bind card_host card_host_sva #(.WAKE_CYC(WAKE_CYC), .ADDR_W(ADDR_W)) chk (
    .clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
    .card_o(card_o), .data_i(data_i), .ready_busy_n_i(ready_busy_n_i),
    .write_protect_i(write_protect_i));

// File: sim/card_model.sv
`timescale 1ns/1ns
module card_model #(
    parameter int BUSY_CYC = 40,
    parameter logic [7:0] MAKER = 8'h00,
    parameter logic [7:0] DEVICE = 8'h00
) (
    input wire logic clk_i,
    input wire card_host_pkg::card_pins_t pins_i,
    input wire logic protect_i,
    output logic [15:0] data_o,
    output logic ready_busy_n_o,
    output logic write_protect_o
);
    logic [15:0] mem_q [16];
    logic [15:0] flip_q = 16'h00ff;
    logic [15:0] rd;
    logic [1:0] mode_q;
    logic setup_q;
    logic we_q = 1'b1;
    int busy_q;
    logic [3:0] wi;
    logic sel;
    assign sel = !pins_i.even_lane_enable_n || !pins_i.odd_lane_enable_n;
    // Small array so upper address bits wrap
    assign wi = pins_i.addr[4:1];
    assign write_protect_o = protect_i;
    assign ready_busy_n_o = busy_q == 0;
    initial begin
        for (int i = 0; i < 16; i++) begin
            mem_q[i] = 16'h1234 + 16'(i) * 16'h0f01;
        end
    end
    always @(posedge clk_i) begin
        we_q <= pins_i.we_n;
        flip_q <= {flip_q[14:0], ~flip_q[15]};
        if (pins_i.reset) begin
            mode_q <= 2'd0;
            setup_q <= 1'b0;
            busy_q <= (busy_q != 0) ? 1 : 0;
        end else begin
            if (busy_q != 0) begin
                busy_q <= busy_q - 1;
            end
            if (!we_q && pins_i.we_n && sel && !protect_i) begin
                if (setup_q) begin
                    if (!pins_i.even_lane_enable_n) mem_q[wi][7:0] <= pins_i.dout[7:0];
                    if (!pins_i.odd_lane_enable_n) mem_q[wi][15:8] <= pins_i.dout[15:8];
                    setup_q <= 1'b0;
                    mode_q <= 2'd1;
                    busy_q <= BUSY_CYC;
                end else if (pins_i.dout[15:8] == pins_i.dout[7:0]) begin
                    case (pins_i.dout[7:0])
                        8'hff: mode_q <= 2'd0;
                        8'h70: mode_q <= 2'd1;
                        8'h90: mode_q <= 2'd2;
                        8'h40: setup_q <= 1'b1;
                        default: ;
                    endcase
                end
            end
        end
    end
    always_comb begin
        rd = (mode_q == 2'd1) ? {2{(busy_q == 0) ? 8'h80 : 8'h00}} :
            (mode_q == 2'd2) ? {2{pins_i.addr[1] ? DEVICE : MAKER}} : mem_q[wi];
        // Released lanes show a moving pattern, never the last value
        data_o = flip_q;
        if (!pins_i.reset && !pins_i.oe_n && pins_i.we_n) begin
            if (!pins_i.even_lane_enable_n) data_o[7:0] = rd[7:0];
            if (!pins_i.odd_lane_enable_n) data_o[15:8] = rd[15:8];
        end
    end
endmodule

// File: sim/card_host_tb.sv
`timescale 1ns/1ns
module card_host_tb;
    typedef struct packed {
        logic [31:0] m;
        logic [31:0] v;
    } exp_t;
    localparam logic [7:0] MAKER = 8'h3c; // Arbitrary value
    localparam logic [7:0] DEVICE = 8'hc5; // Arbitrary value
    logic clk_i;
    logic rst_i;
    logic prot_q;
    card_host_pkg::wb_req_t wb_q;
    logic wb_ack;
    logic [31:0] wb_dat;
    card_host_pkg::card_pins_t pins;
    logic [15:0] cdata;
    logic rdy;
    logic wp;
    exp_t exp_q[$];
    int error_cnt;
    int num_checks;
    logic [31:0] seed;
    logic [31:0] rd;
    logic [25:0] a;
    logic [15:0] d;
    card_host #(.WAKE_CYC(4)) uut (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_q), .wb_ack_o(wb_ack),
        .wb_dat_o(wb_dat), .card_o(pins), .data_i(cdata), .ready_busy_n_i(rdy),
        .write_protect_i(wp));
    card_model #(.MAKER(MAKER), .DEVICE(DEVICE)) cm (.clk_i(clk_i), .pins_i(pins),
        .protect_i(prot_q), .data_o(cdata), .ready_busy_n_o(rdy), .write_protect_o(wp));
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [15:0] mval(input logic [3:0] i);
        return 16'h1234 + 16'(i) * 16'h0f01;
    endfunction
    task automatic test_done();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wb_cycle(input logic w, input logic [7:0] ad, input logic [31:0] dt);
        int n;
        n = 0;
        wb_q <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: ad, sel: 4'hf, dat: dt};
        @(posedge clk_i);
        while (wb_ack !== 1'b1) begin
            @(posedge clk_i);
            n++;
            if (n > 50) begin
                error_cnt++;
                test_done();
            end
        end
        rd = wb_dat;
        wb_q <= '0;
        @(posedge clk_i);
    endtask
    task automatic wb_read(input logic [7:0] ad, input logic [31:0] m, input logic [31:0] v);
        exp_q.push_back('{m: m, v: v});
        wb_cycle(1'b0, ad, 32'h0);
    endtask
    // Poll status until one bit settles; bounded so a hang still ends the run
    task automatic wait_st(input int b, input logic v);
        int n;
        n = 0;
        do begin
            wb_cycle(1'b0, card_host_pkg::STATUS_OFS, 32'h0);
            n++;
        end while (rd[b] !== v && n < 500);
        if (n >= 500) begin
            error_cnt++;
            test_done();
        end
    endtask
    task automatic card_op(input logic [31:0] ctl, input logic [25:0] ad, input logic [15:0] dt,
        input int b);
        wb_cycle(1'b1, card_host_pkg::ADDR_OFS, {6'h0, ad});
        wb_cycle(1'b1, card_host_pkg::WDATA_OFS, {16'h0, dt});
        wb_cycle(1'b1, card_host_pkg::CTRL_OFS, ctl);
        wait_st(b, 1'b1);
    endtask
    always @(posedge clk_i) begin
        if (wb_ack === 1'b1 && !wb_q.we && exp_q.size() > 0) begin
            check(wb_dat & exp_q[0].m, exp_q[0].v);
            void'(exp_q.pop_front());
        end
    end
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    initial begin
        rst_i = 1'b1;
        wb_q = '0;
        prot_q = 1'b0;
        seed = 32'd92554;
        error_cnt = 0;
        num_checks = 0;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        wait_st(5, 1'b0);
        for (int l = 1; l < 4; l++) begin
            card_op(32'(1 + 4 * l), 26'(2 * l), 16'h0, 3);
            wb_read(8'h0c, 32'hffffffff, {16'h0, mval(4'(l)) & {{8{l[1]}}, {8{l[0]}}}});
        end
        rd = xs();
        a = rd[25:0];
        rd = xs();
        d = rd[15:0];
        card_op(32'h1f, a, 16'h0040, 3);
        card_op(32'h0f, a, d, 3);
        wb_read(8'h10, 32'h2, 32'h0);
        wait_st(1, 1'b1);
        card_op(32'h1f, a, 16'h00ff, 3);
        card_op(32'h0d, a ^ 26'h0400, 16'h0, 3);
        wb_read(8'h0c, 32'hffffffff, {16'h0, d});
        card_op(32'h1f, a, 16'h0070, 3);
        card_op(32'h0d, a, 16'h0, 3);
        wb_read(8'h0c, 32'hffffffff, 32'h8080);
        card_op(32'h1f, a, 16'h0090, 3);
        for (int k = 0; k < 2; k++) begin
            card_op(32'h0d, 26'(2 * k), 16'h0, 3);
            wb_read(8'h0c, 32'hffffffff, {16'h0, {2{k[0] ? DEVICE : MAKER}}});
        end
        // Reset lands before the strobe, so the old word must survive
        card_op(32'h1f, a, 16'h0040, 3);
        wb_cycle(1'b1, 8'h00, 32'h0f);
        wb_cycle(1'b1, 8'h00, 32'h40);
        wb_read(8'h10, 32'h20, 32'h20);
        wait_st(5, 1'b0);
        card_op(32'h0d, a, 16'h0, 3);
        wb_read(8'h0c, 32'hffffffff, {16'h0, d});
        wb_cycle(1'b1, 8'h00, 32'h20);
        wb_read(8'h10, 32'h20, 32'h20);
        wb_cycle(1'b1, 8'h00, 32'h0);
        wait_st(5, 1'b0);
        prot_q <= 1'b1;
        repeat (50) @(posedge clk_i);
        wb_read(8'h10, 32'h4, 32'h4);
        card_op(32'h0f, a, ~d, 4);
        wb_read(8'h10, 32'h18, 32'h10);
        prot_q <= 1'b0;
        card_op(32'h0d, a, 16'h0, 3);
        wb_read(8'h0c, 32'hffffffff, {16'h0, d});
        wb_read(8'h40, 32'hffffffff, 32'h0);
        wb_read(8'h04, 32'hffffffff, {6'h0, a});
        test_done();
    end
endmodule
